// *** hdl/adcseq_top.sv ***
// Converter control: reference, input selection, conversion sequencing
//
// Our own choices: the register offsets and the plain strobed port.
module adcseq_top #(
    parameter int NUM_PINS = 11,
    parameter int DELAY_WIDTH = 8
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] rdata_out,
    // Trigger and converter core
    input wire logic pwm_event_in,
    input wire logic [11:0] core_code_in,
    // Analog switch controls
    output logic [1:0] ref_source_sel_out,
    output logic ext_ref_pin_connect_out,
    output logic ext_amp_ref_pin_connect_out,
    output logic ref_amp_enable_out,
    output logic [1:0] ref_amp_gain_sel_out,
    output logic ref_amp_input_sel_out,
    output logic [NUM_PINS-1:0] ext_channel_connect_out,
    output logic [5:0] internal_source_connect_out,
    output logic converter_power_out,
    output logic core_sample_out,
    output logic core_convert_out,
    // Pin sharing overrides
    output logic [NUM_PINS-1:0] pin_analog_out,
    output logic [NUM_PINS-1:0] pin_pullup_off_out,
    // Interrupt
    output logic conv_irq_out
);
    import adcseq_pkg::*;

    default clocking cb_assert @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    logic [9:0] ctrl0;
    logic [5:0] ctrl1;
    logic [8:0] ctrl2;
    logic [DELAY_WIDTH-1:0] trigger_delay_count;
    logic [NUM_PINS-1:0] pin_analog_sel;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [11:0] last_code;
    logic conv_busy_flag;
    logic conv_irq_flag;
    adcseq_state_e state;
    logic [6:0] div_count;
    logic [3:0] period_count;
    logic [DELAY_WIDTH-1:0] delay_count;
    logic start_prev;
    logic start_pulse;
    logic trigger;
    logic adc_tick;
    logic done;
    logic [2:0] internal_signal_sel;
    logic [3:0] external_channel_sel;
    logic [1:0] ref_source_sel;
    logic result_format_sel;
    logic trigger_source_sel;
    logic delayed_start_enable;
    logic converter_power_enable;

    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        div_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction : div_mask

    function automatic logic is_write(input logic [7:0] a,
                                      input logic [7:0] target,
                                      input logic wr);
        is_write = wr && (a == target);
    endfunction : is_write

    assign internal_signal_sel = ctrl1[C1_INSIG_LSB +: 3];
    assign external_channel_sel = ctrl0[C0_CHAN_LSB +: 4];
    assign ref_source_sel = ctrl2[C2_REFSRC_LSB +: 2];
    assign result_format_sel = ctrl2[C2_FORMAT];
    assign trigger_source_sel = ctrl2[C2_TRIG_SRC];
    assign delayed_start_enable = ctrl2[C2_DLY_EN];
    assign converter_power_enable = ctrl0[C0_PWR];

    // Start fires on the falling half of the software pulse
    assign start_pulse = start_prev && !ctrl0[C0_START];
    assign trigger = converter_power_enable && (trigger_source_sel ?
        pwm_event_in : start_pulse);
    assign adc_tick = (div_count == div_mask(ctrl1[C1_DIV_LSB +: 3]));
    assign done = (state == ADCSEQ_CONVERT) && adc_tick &&
        (period_count == 4'(CONVERT_PERIODS - 1));

    // Control registers; software writes load every bit, busy and irq flag read back from hardware
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl0 <= CTRL0_RESET;
            ctrl1 <= CTRL1_RESET;
            ctrl2 <= CTRL2_RESET;
            trigger_delay_count <= '0;
            pin_analog_sel <= '0;
        end else begin
            if (is_write(addr_in, ADDR_CTRL0, write_in)) begin
                ctrl0 <= wdata_in[9:0];
            end
            if (is_write(addr_in, ADDR_CTRL1, write_in)) begin
                ctrl1 <= wdata_in[5:0];
            end
            if (is_write(addr_in, ADDR_CTRL2, write_in)) begin
                ctrl2 <= wdata_in[8:0];
            end
            if (is_write(addr_in, ADDR_DELAY, write_in)) begin
                trigger_delay_count <= wdata_in[DELAY_WIDTH-1:0];
            end
            if (is_write(addr_in, ADDR_PINSEL, write_in)) begin
                pin_analog_sel <= wdata_in[NUM_PINS-1:0];
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= ctrl0[C0_START];
        end
    end

    // Sequencer
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ADCSEQ_IDLE;
            div_count <= '0;
            period_count <= '0;
            delay_count <= '0;
        end else if (!converter_power_enable) begin
            state <= ADCSEQ_IDLE;
            div_count <= '0;
            period_count <= '0;
        end else begin
            div_count <= adc_tick ? 7'h00 : 7'(div_count + 7'h01);
            case (state)
                ADCSEQ_IDLE: begin
                    if (trigger) begin
                        div_count <= '0;
                        period_count <= '0;
                        // A zero count means no extra wait
                        if (trigger_source_sel && delayed_start_enable &&
                            trigger_delay_count != '0) begin
                            delay_count <= trigger_delay_count;
                            state <= ADCSEQ_DELAY;
                        end else begin
                            state <= ADCSEQ_SAMPLE;
                        end
                    end
                end
                ADCSEQ_DELAY: begin
                    div_count <= '0;
                    if (delay_count == DELAY_WIDTH'(1)) begin
                        state <= ADCSEQ_SAMPLE;
                    end else begin
                        delay_count <= delay_count - DELAY_WIDTH'(1);
                    end
                end
                ADCSEQ_SAMPLE: begin
                    if (adc_tick) begin
                        if (period_count == 4'(SAMPLE_PERIODS - 1)) begin
                            period_count <= '0;
                            state <= ADCSEQ_CONVERT;
                        end else begin
                            period_count <= period_count + 4'h1;
                        end
                    end
                end
                ADCSEQ_CONVERT: begin
                    if (adc_tick) begin
                        if (done) begin
                            period_count <= '0;
                            state <= ADCSEQ_IDLE;
                        end else begin
                            period_count <= period_count + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= ADCSEQ_IDLE;
                end
            endcase
        end
    end

    // Busy and result
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            conv_busy_flag <= 1'b0;
            last_code <= '0;
        end else if (!converter_power_enable) begin
            conv_busy_flag <= 1'b0;
        end else if (state == ADCSEQ_IDLE && trigger) begin
            conv_busy_flag <= 1'b1;
        end else if (done) begin
            conv_busy_flag <= 1'b0;
            last_code <= core_code_in;
        end
    end

    // Core output is already a 12-bit code with the offset transfer curve
    always_comb begin
        if (result_format_sel) begin
            result_high_byte = {4'h0, last_code[11:8]};
            result_low_byte = last_code[7:0];
        end else begin
            result_high_byte = last_code[11:4];
            result_low_byte = {last_code[3:0], 4'h0};
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            conv_irq_flag <= 1'b0;
        end else if (done) begin
            conv_irq_flag <= 1'b1;
        end else if (is_write(addr_in, ADDR_CTRL0, write_in) &&
                     !wdata_in[C0_IRQ_FLAG]) begin
            conv_irq_flag <= 1'b0;
        end
    end

    // Read port
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (read_in) begin
            case (addr_in)
                ADDR_CTRL0: rdata_out <= 32'({conv_irq_flag, ctrl0[8:6],
                    conv_busy_flag, ctrl0[4:0]});
                ADDR_CTRL1: rdata_out <= 32'(ctrl1);
                ADDR_CTRL2: rdata_out <= 32'(ctrl2);
                ADDR_DELAY: rdata_out <= 32'(trigger_delay_count);
                ADDR_RES_HI: rdata_out <= 32'(result_high_byte);
                ADDR_RES_LO: rdata_out <= 32'(result_low_byte);
                ADDR_PINSEL: rdata_out <= 32'(pin_analog_sel);
                ADDR_CODE: rdata_out <= 32'(last_code);
                default: rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // Analog switch controls, registered
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ref_source_sel_out <= REF_SUPPLY;
            ext_ref_pin_connect_out <= 1'b0;
            ext_amp_ref_pin_connect_out <= 1'b0;
            ref_amp_enable_out <= 1'b0;
            ref_amp_gain_sel_out <= '0;
            ref_amp_input_sel_out <= 1'b0;
            converter_power_out <= 1'b0;
            core_sample_out <= 1'b0;
            core_convert_out <= 1'b0;
            conv_irq_out <= 1'b0;
        end else begin
            ref_source_sel_out <= ref_source_sel;
            ext_ref_pin_connect_out <= (ref_source_sel == REF_EXT_PIN);
            // Amp pin feeds only an amplifier whose output is in use
            ext_amp_ref_pin_connect_out <= ref_source_sel[1] &&
                !ctrl2[C2_AMP_IN] && ctrl2[C2_AMP_EN];
            ref_amp_enable_out <= ctrl2[C2_AMP_EN];
            ref_amp_gain_sel_out <= ctrl2[C2_GAIN_LSB +: 2];
            ref_amp_input_sel_out <= ctrl2[C2_AMP_IN];
            converter_power_out <= converter_power_enable;
            core_sample_out <= (state == ADCSEQ_SAMPLE);
            core_convert_out <= (state == ADCSEQ_CONVERT);
            conv_irq_out <= conv_irq_flag && ctrl0[C0_IRQ_EN] &&
                ctrl0[C0_GIE];
        end
    end

    // Input multiplexer
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ext_channel_connect_out <= '0;
            internal_source_connect_out <= '0;
        end else begin
            ext_channel_connect_out <= '0;
            internal_source_connect_out <= '0;
            case (internal_signal_sel)
                INSIG_NONE: begin
                    if (external_channel_sel <= LAST_EXT_CHANNEL) begin
                        ext_channel_connect_out[external_channel_sel]
                            <= 1'b1;
                    end
                end
                INSIG_OPAMP: internal_source_connect_out[SRC_OPAMP]
                    <= 1'b1;
                INSIG_SUPPLY: internal_source_connect_out[SRC_SUPPLY]
                    <= 1'b1;
                INSIG_HALF_SUPPLY:
                    internal_source_connect_out[SRC_HALF_SUPPLY] <= 1'b1;
                INSIG_VREF: internal_source_connect_out[SRC_VREF]
                    <= 1'b1;
                INSIG_HALF_VREF:
                    internal_source_connect_out[SRC_HALF_VREF] <= 1'b1;
                default: internal_source_connect_out[SRC_GROUND]
                    <= 1'b1;
            endcase
        end
    end

    // Pin sharing: analog function overrides direction and pull-high
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_analog_out <= '0;
            pin_pullup_off_out <= '0;
        end else begin
            pin_analog_out <= pin_analog_sel;
            pin_pullup_off_out <= pin_analog_sel;
        end
    end

    a_sample_len: assert property ($rose(core_sample_out) &&
        ctrl1[C1_DIV_LSB +: 3] == 3'h0 && converter_power_enable |->
        core_sample_out[*4] ##1 core_convert_out)
    else $error("sample phase length wrong");

    a_busy_clear: assert property (done && converter_power_enable |=>
        !conv_busy_flag && last_code == $past(core_code_in))
    else $error("result not updated with busy clear");

    a_busy_set: assert property (state == ADCSEQ_IDLE && trigger |=>
        conv_busy_flag)
    else $error("busy not set on start");

    a_sw_start: assert property (converter_power_enable &&
        !trigger_source_sel && !conv_busy_flag && start_prev &&
        !ctrl0[C0_START] |=> conv_busy_flag)
    else $error("software pulse did not start");

    a_trig_src: assert property (state == ADCSEQ_IDLE &&
        trigger_source_sel && !pwm_event_in |=> state == ADCSEQ_IDLE)
    else $error("start without selected trigger");

    a_delay_step: assert property (converter_power_enable &&
        state == ADCSEQ_DELAY |=> state == ($past(delay_count) ==
        DELAY_WIDTH'(1) ? ADCSEQ_SAMPLE : ADCSEQ_DELAY))
    else $error("trigger delay did not step");

    a_irq_flag: assert property (done |=> conv_irq_flag)
    else $error("irq flag not set on completion");

    a_irq_out: assert property (conv_irq_flag && ctrl0[C0_IRQ_EN] &&
        ctrl0[C0_GIE] |=> conv_irq_out)
    else $error("irq not raised");

    a_ext_off: assert property (internal_signal_sel != INSIG_NONE |=>
        ext_channel_connect_out == '0)
    else $error("external channel left connected");

    a_ref_pins: assert property (ref_source_sel[1] |=>
        !ext_ref_pin_connect_out)
    else $error("external ref pin left connected");

    a_power_off: assert property (!converter_power_enable |=>
        state == ADCSEQ_IDLE && !conv_busy_flag ##1
        !core_sample_out && !core_convert_out)
    else $error("converter active while powered down");

endmodule : adcseq_top

// *** inc/adcseq_pkg.sv ***
// Package for the converter control block: register map, fields, timing
package adcseq_pkg;

    // Register offsets, byte addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL2 = 8'h08;
    localparam logic [7:0] ADDR_DELAY = 8'h0c;
    localparam logic [7:0] ADDR_RES_HI = 8'h10;
    localparam logic [7:0] ADDR_RES_LO = 8'h14;
    localparam logic [7:0] ADDR_PINSEL = 8'h18;
    localparam logic [7:0] ADDR_CODE = 8'h1c;

    // CTRL0 fields
    localparam int C0_CHAN_LSB = 0;
    localparam int C0_START = 4;
    localparam int C0_BUSY = 5;
    localparam int C0_PWR = 6;
    localparam int C0_IRQ_EN = 7;
    localparam int C0_GIE = 8;
    localparam int C0_IRQ_FLAG = 9;

    // CTRL1 fields
    localparam int C1_DIV_LSB = 0;
    localparam int C1_INSIG_LSB = 3;

    // CTRL2 fields
    localparam int C2_REFSRC_LSB = 0;
    localparam int C2_AMP_EN = 2;
    localparam int C2_GAIN_LSB = 3;
    localparam int C2_AMP_IN = 5;
    localparam int C2_TRIG_SRC = 6;
    localparam int C2_DLY_EN = 7;
    localparam int C2_FORMAT = 8;

    // Reset values
    localparam logic [9:0] CTRL0_RESET = 10'h000;
    localparam logic [5:0] CTRL1_RESET = 6'h00;
    localparam logic [8:0] CTRL2_RESET = 9'h000;
    localparam logic [7:0] DELAY_RESET = 8'h00;

    // Reference source codes
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_EXT_PIN = 2'h1;

    // Internal signal codes
    localparam logic [2:0] INSIG_NONE = 3'h0;
    localparam logic [2:0] INSIG_OPAMP = 3'h1;
    localparam logic [2:0] INSIG_SUPPLY = 3'h2;
    localparam logic [2:0] INSIG_HALF_SUPPLY = 3'h3;
    localparam logic [2:0] INSIG_VREF = 3'h4;
    localparam logic [2:0] INSIG_HALF_VREF = 3'h5;
    localparam logic [3:0] LAST_EXT_CHANNEL = 4'ha;

    // Analog selector one-hot positions for internal sources
    localparam int SRC_OPAMP = 0;
    localparam int SRC_SUPPLY = 1;
    localparam int SRC_HALF_SUPPLY = 2;
    localparam int SRC_VREF = 3;
    localparam int SRC_HALF_VREF = 4;
    localparam int SRC_GROUND = 5;

    // Conversion timing in converter clock periods
    localparam int SAMPLE_PERIODS = 4;
    localparam int CONVERT_PERIODS = 12;
    localparam int TOTAL_PERIODS = SAMPLE_PERIODS + CONVERT_PERIODS;

    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b00,
        ADCSEQ_DELAY = 2'b01,
        ADCSEQ_SAMPLE = 2'b10,
        ADCSEQ_CONVERT = 2'b11
    } adcseq_state_e;

endpackage : adcseq_pkg

// *** sim/test_adc_input_ref_sequencer.sv ***
// Self-checking bench for the converter control block
module test_adc_input_ref_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import adcseq_pkg::*;

    typedef struct {
        logic [31:0] exp;
        string what;
    } airs_note_s;

    logic clock_in;
    logic rst_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic write_in;
    logic read_in;
    logic [31:0] rdata_out;
    logic pwm_event_in;
    logic [11:0] core_code_in;
    logic [1:0] ref_source_sel_out;
    logic ext_ref_pin_connect_out;
    logic ext_amp_ref_pin_connect_out;
    logic ref_amp_enable_out;
    logic [1:0] ref_amp_gain_sel_out;
    logic ref_amp_input_sel_out;
    logic [10:0] ext_channel_connect_out;
    logic [5:0] internal_source_connect_out;
    logic converter_power_out;
    logic core_sample_out;
    logic core_convert_out;
    logic [10:0] pin_analog_out;
    logic [10:0] pin_pullup_off_out;
    logic conv_irq_out;
    int n_errors = 0;
    int n_tests = 0;
    airs_note_s notes[$];
    logic rd_pend = 1'b0;
    logic [15:0] rnd;
    logic [31:0] ctrl0;
    logic [31:0] c2;
    int lat0, lat1, ns, nc, nd, seen;

    adcseq_top #(.NUM_PINS(11), .DELAY_WIDTH(8)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .pwm_event_in(pwm_event_in),
        .core_code_in(core_code_in),
        .ref_source_sel_out(ref_source_sel_out),
        .ext_ref_pin_connect_out(ext_ref_pin_connect_out),
        .ext_amp_ref_pin_connect_out(ext_amp_ref_pin_connect_out),
        .ref_amp_enable_out(ref_amp_enable_out),
        .ref_amp_gain_sel_out(ref_amp_gain_sel_out),
        .ref_amp_input_sel_out(ref_amp_input_sel_out),
        .ext_channel_connect_out(ext_channel_connect_out),
        .internal_source_connect_out(internal_source_connect_out),
        .converter_power_out(converter_power_out),
        .core_sample_out(core_sample_out),
        .core_convert_out(core_convert_out),
        .pin_analog_out(pin_analog_out),
        .pin_pullup_off_out(pin_pullup_off_out),
        .conv_irq_out(conv_irq_out));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string what, input logic [31:0] seen_v,
                         input logic [31:0] exp_v);
        n_tests++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask : check

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // Bus tasks set the write and read strobes; wr and rd let one edge pass, idle lets n
    task automatic idle(input int n);
        repeat (n) begin
            write_in <= 1'b0;
            read_in <= 1'b0;
            pwm_event_in <= 1'b0;
            @(posedge clock_in);
        end
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        read_in <= 1'b0;
        @(posedge clock_in);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        notes.push_back('{exp: e, what: what});
        addr_in <= a;
        write_in <= 1'b0;
        read_in <= 1'b1;
        @(posedge clock_in);
    endtask : rd

    // Read data stand only in the cycle after the strobe
    always @(posedge clock_in) begin
        if (rd_pend && notes.size() > 0) begin
            check(notes[0].what, rdata_out, notes[0].exp);
            void'(notes.pop_front());
        end
        rd_pend <= read_in & ~rst_in;
    end

    // Software start or PWM pulse, then phase lengths in system clocks
    task automatic conv(input logic sw, output int lat, output int n_s,
                        output int n_c);
        if (sw) begin
            wr(ADDR_CTRL0, ctrl0 | (32'h1 << C0_START));
            wr(ADDR_CTRL0, ctrl0);
        end else begin
            write_in <= 1'b0;
            pwm_event_in <= 1'b1;
            @(posedge clock_in);
        end
        lat = 0;
        n_s = 0;
        n_c = 0;
        while (core_sample_out !== 1'b1 && lat < 400) begin
            idle(1);
            lat++;
        end
        while (core_sample_out === 1'b1 && n_s < 2000) begin
            idle(1);
            n_s++;
        end
        while (core_convert_out === 1'b1 && n_c < 4000) begin
            idle(1);
            n_c++;
        end
    endtask : conv

    task automatic quiet_window(output int hits);
        hits = 0;
        repeat (40) begin
            idle(1);
            if (core_sample_out !== 1'b0)
                hits++;
        end
    endtask : quiet_window

    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        $display("Watchdog expired before the tests ended");
        end_of_test();
    end

    initial begin
        rst_in = 1'b1;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        write_in = 1'b0;
        read_in = 1'b0;
        pwm_event_in = 1'b0;
        core_code_in = 12'h000;
        rnd = 16'h0004;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rd(ADDR_CTRL0, 32'(CTRL0_RESET), "ctrl0 reset");
        rd(ADDR_CTRL1, 32'(CTRL1_RESET), "ctrl1 reset");
        rd(ADDR_CTRL2, 32'(CTRL2_RESET), "ctrl2 reset");
        rd(ADDR_DELAY, 32'(DELAY_RESET), "delay reset");
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0, "unmapped");
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            c2 = {26'h0, i[3], rnd[1:0], i[2], i[1:0]};
            wr(ADDR_CTRL2, c2);
            idle(3);
            check("ref sel", ref_source_sel_out, c2[1:0]);
            check("ref pin", ext_ref_pin_connect_out, c2[1:0] == 2'h1);
            check("amp pin", ext_amp_ref_pin_connect_out,
                  c2[1] & c2[2] & ~c2[5]);
            check("amp en", ref_amp_enable_out, c2[2]);
            check("gain", ref_amp_gain_sel_out, c2[4:3]);
            check("amp in", ref_amp_input_sel_out, c2[5]);
        end
        ctrl0 = 32'h1 << C0_PWR;
        for (int s = 0; s < 8; s++) begin
            for (int ch = 0; ch < 16; ch++) begin
                wr(ADDR_CTRL1, 32'(s) << C1_INSIG_LSB);
                wr(ADDR_CTRL0, ctrl0 | 32'(ch));
                idle(3);
                check("ext chan", ext_channel_connect_out,
                      (s == 0 && ch <= 10) ? 32'h1 << ch : 32'h0);
                check("int src", internal_source_connect_out,
                      (s == 0) ? 32'h0 : 32'h1 << ((s > 5) ? 5 : s - 1));
            end
        end
        repeat (4) begin
            rnd = lfsr(rnd);
            wr(ADDR_PINSEL, {21'h0, rnd[10:0]});
            idle(3);
            check("pin analog", pin_analog_out, rnd[10:0]);
            check("pullup off", pin_pullup_off_out, rnd[10:0]);
        end
        ctrl0 = (32'h1 << C0_PWR) | (32'h1 << C0_IRQ_EN) | (32'h1 << C0_GIE);
        for (int d = 0; d < 3; d++) begin
            rnd = lfsr(rnd);
            core_code_in <= rnd[11:0];
            wr(ADDR_CTRL1, 32'(d));
            wr(ADDR_CTRL2, 32'(d % 2) << C2_FORMAT);
            conv(1'b1, lat0, ns, nc);
            check("sample len", ns, 4 << d);
            check("convert len", nc, 12 << d);
            rd(ADDR_RES_HI, (d % 2) ? rnd[11:8] : rnd[11:4], "res hi");
            rd(ADDR_RES_LO, (d % 2) ? rnd[7:0] : {rnd[3:0], 4'h0},
               "res lo");
            rd(ADDR_CTRL0, ctrl0 | (32'h1 << C0_IRQ_FLAG), "done");
            idle(2);
            check("irq", conv_irq_out, 1'b1);
        end
        // Busy mid-run, then a power-off abort
        wr(ADDR_CTRL0, ctrl0 | (32'h1 << C0_START));
        wr(ADDR_CTRL0, ctrl0);
        idle(6);
        rd(ADDR_CTRL0, ctrl0 | (32'h1 << C0_BUSY), "busy");
        wr(ADDR_CTRL0, ctrl0 & ~(32'h1 << C0_PWR));
        idle(3);
        check("power", converter_power_out, 1'b0);
        check("phases", {core_sample_out, core_convert_out}, 2'b00);
        check("irq clear", conv_irq_out, 1'b0);
        rd(ADDR_CTRL0, ctrl0 & ~(32'h1 << C0_PWR), "abort");
        wr(ADDR_CTRL0, ctrl0);
        wr(ADDR_CTRL1, 32'h0);
        wr(ADDR_CTRL2, 32'h1 << C2_TRIG_SRC);
        conv(1'b0, lat0, ns, nc);
        check("pwm sample", ns, 4);
        rnd = lfsr(rnd);
        nd = 1 + rnd % 20;
        wr(ADDR_DELAY, 32'(nd));
        wr(ADDR_CTRL2, (32'h1 << C2_TRIG_SRC) | (32'h1 << C2_DLY_EN));
        conv(1'b0, lat1, ns, nc);
        check("pwm delay", lat1 - lat0, nd);
        wr(ADDR_CTRL0, ctrl0 | (32'h1 << C0_START));
        wr(ADDR_CTRL0, ctrl0);
        quiet_window(seen);
        check("sw ignored", seen, 0);
        wr(ADDR_CTRL2, 32'h0);
        write_in <= 1'b0;
        pwm_event_in <= 1'b1;
        @(posedge clock_in);
        quiet_window(seen);
        check("pwm ignored", seen, 0);
        idle(3);
        end_of_test();
    end

endmodule : test_adc_input_ref_sequencer
